// [rtl/bst_defines.svh]
// Constants of the boundary-scan test port: instruction codes, widths, capture values.
// Assumes inclusion by bare name from the package and the port modules.
`ifndef BST_DEFINES_SVH
`define BST_DEFINES_SVH

`define BST_IR_W 4
`define BST_DR_W 32
`define BST_IR_EXTEST 4'h0
`define BST_IR_IDCODE 4'h2
`define BST_IR_BYPASS 4'hF
`define BST_IR_RESET `BST_IR_IDCODE
// Fixed low bits 01 loaded into the instruction shifter at capture
`define BST_IR_CAPTURE 4'h1
// Arbitrary value; bit 0 must stay set
`define BST_IDCODE_DEFAULT 32'h0000_0001
`define BST_TDO_IDLE 1'h0

`endif

// [rtl/bst_pkg.sv]
// Types of the boundary-scan test port: controller states and state records.
// Assumes bst_defines.svh on the include path.
`include "bst_defines.svh"

package bst_pkg;

	// Gray steps along reset, idle, data scan and instruction scan paths
	typedef enum logic [3:0] {
		BST_RESET = 4'h0,
		BST_IDLE = 4'h1,
		BST_SEL_DR = 4'h3,
		BST_CAP_DR = 4'h2,
		BST_SHIFT_DR = 4'h6,
		BST_EXIT1_DR = 4'h7,
		BST_PAUSE_DR = 4'h5,
		BST_EXIT2_DR = 4'h4,
		BST_UPD_DR = 4'hC,
		BST_SEL_IR = 4'hD,
		BST_CAP_IR = 4'hF,
		BST_SHIFT_IR = 4'hE,
		BST_EXIT1_IR = 4'hA,
		BST_PAUSE_IR = 4'hB,
		BST_EXIT2_IR = 4'h9,
		BST_UPD_IR = 4'h8
	} bst_state_t;

	// Rising-edge state of the test clock domain
	typedef struct packed {
		bst_state_t state;
		logic [`BST_IR_W-1:0] ir;
		logic [`BST_IR_W-1:0] ir_sh;
		logic [`BST_DR_W-1:0] dr_sh;
		logic byp;
		logic upd_tgl;
	} bst_tck_t;

	// Falling-edge output stage
	typedef struct packed {
		logic tdo;
		logic tdo_oe;
	} bst_neg_t;

	// System clock domain view
	typedef struct packed {
		logic [1:0] rst_sh;
		logic tgl_seen;
		logic ir_upd;
		logic [`BST_IR_W-1:0] ir;
		logic in_reset;
	} bst_sys_t;

endpackage : bst_pkg

// [rtl/bst_port.sv]
// Boundary-scan test access port: state controller, instruction,
// identification and bypass registers on the test clock, with a status view
// carried into the system clock domain.
// Assumes the board resolves the data output pin from tdo and tdo_oe.
`timescale 1ns/1ps
`include "bst_defines.svh"

// Function
// - Sample mode and data on rising edge
// - Link outputs tdo and tdo_oe change on falling edge only
// - Data output driven only while shifting
// - Shift data input into selected register
// - Controller follows standard state diagram
// - Test reset clears controller asynchronously
// - Controller resets itself at power-up
// - Open mode input reads as high
// - Open data input reads as high
module bst_port #(
	parameter logic [`BST_DR_W-1:0] IDCODE = `BST_IDCODE_DEFAULT
) (
	// System clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Test link
	input wire logic tck,
	input wire logic trst_n,
	input wire logic tms,
	input wire logic tms_conn,
	input wire logic tdi,
	input wire logic tdi_conn,
	output logic tdo,
	output logic tdo_oe,
	// System side status
	output logic sys_tap_reset,
	output logic sys_ir_upd,
	output logic [`BST_IR_W-1:0] sys_ir
);

	bst_pkg::bst_tck_t r;
	bst_pkg::bst_tck_t next_r;
	bst_pkg::bst_neg_t n;
	bst_pkg::bst_neg_t next_n;
	bst_pkg::bst_sys_t s;
	bst_pkg::bst_sys_t next_s;

	logic tap_arst_n;
	logic tms_eff;
	logic tdi_eff;
	logic sel_idcode;
	logic [1:0] synced;

	// Power-up reset and test reset both clear the controller at once
	assign tap_arst_n = trst_n & rst_n;

	// Internal pull-ups: an open pin reads high
	assign tms_eff = tms | ~tms_conn;
	assign tdi_eff = tdi | ~tdi_conn;

	// Unknown and unused codes fall back to bypass
	assign sel_idcode = (r.ir == `BST_IR_IDCODE);

	always_comb begin
		next_r = r;
		// Controller steered by the mode input on each rising edge
		unique case (r.state)
			bst_pkg::BST_RESET: begin
				next_r.state = tms_eff ? bst_pkg::BST_RESET : bst_pkg::BST_IDLE;
			end
			bst_pkg::BST_IDLE: begin
				next_r.state = tms_eff ? bst_pkg::BST_SEL_DR : bst_pkg::BST_IDLE;
			end
			bst_pkg::BST_SEL_DR: begin
				next_r.state = tms_eff ? bst_pkg::BST_SEL_IR : bst_pkg::BST_CAP_DR;
			end
			bst_pkg::BST_CAP_DR: begin
				next_r.state = tms_eff ? bst_pkg::BST_EXIT1_DR : bst_pkg::BST_SHIFT_DR;
			end
			bst_pkg::BST_SHIFT_DR: begin
				next_r.state = tms_eff ? bst_pkg::BST_EXIT1_DR : bst_pkg::BST_SHIFT_DR;
			end
			bst_pkg::BST_EXIT1_DR: begin
				next_r.state = tms_eff ? bst_pkg::BST_UPD_DR : bst_pkg::BST_PAUSE_DR;
			end
			bst_pkg::BST_PAUSE_DR: begin
				next_r.state = tms_eff ? bst_pkg::BST_EXIT2_DR : bst_pkg::BST_PAUSE_DR;
			end
			bst_pkg::BST_EXIT2_DR: begin
				next_r.state = tms_eff ? bst_pkg::BST_UPD_DR : bst_pkg::BST_SHIFT_DR;
			end
			bst_pkg::BST_UPD_DR: begin
				next_r.state = tms_eff ? bst_pkg::BST_SEL_DR : bst_pkg::BST_IDLE;
			end
			bst_pkg::BST_SEL_IR: begin
				next_r.state = tms_eff ? bst_pkg::BST_RESET : bst_pkg::BST_CAP_IR;
			end
			bst_pkg::BST_CAP_IR: begin
				next_r.state = tms_eff ? bst_pkg::BST_EXIT1_IR : bst_pkg::BST_SHIFT_IR;
			end
			bst_pkg::BST_SHIFT_IR: begin
				next_r.state = tms_eff ? bst_pkg::BST_EXIT1_IR : bst_pkg::BST_SHIFT_IR;
			end
			bst_pkg::BST_EXIT1_IR: begin
				next_r.state = tms_eff ? bst_pkg::BST_UPD_IR : bst_pkg::BST_PAUSE_IR;
			end
			bst_pkg::BST_PAUSE_IR: begin
				next_r.state = tms_eff ? bst_pkg::BST_EXIT2_IR : bst_pkg::BST_PAUSE_IR;
			end
			bst_pkg::BST_EXIT2_IR: begin
				next_r.state = tms_eff ? bst_pkg::BST_UPD_IR : bst_pkg::BST_SHIFT_IR;
			end
			bst_pkg::BST_UPD_IR: begin
				next_r.state = tms_eff ? bst_pkg::BST_SEL_DR : bst_pkg::BST_IDLE;
			end
		endcase

		// Register actions of the current state
		unique case (r.state)
			bst_pkg::BST_RESET: begin
				next_r.ir = `BST_IR_RESET;
			end
			bst_pkg::BST_CAP_DR: begin
				next_r.dr_sh = sel_idcode ? IDCODE : '0;
				next_r.byp = 1'h0;
			end
			bst_pkg::BST_SHIFT_DR: begin
				if (sel_idcode) begin
					next_r.dr_sh = {tdi_eff, r.dr_sh[`BST_DR_W-1:1]};
				end else begin
					next_r.byp = tdi_eff;
				end
			end
			bst_pkg::BST_CAP_IR: begin
				next_r.ir_sh = `BST_IR_CAPTURE;
			end
			bst_pkg::BST_SHIFT_IR: begin
				next_r.ir_sh = {tdi_eff, r.ir_sh[`BST_IR_W-1:1]};
			end
			bst_pkg::BST_UPD_IR: begin
				next_r.ir = r.ir_sh;
				// Event for the system side; ir stays put until the next update or controller reset
				next_r.upd_tgl = ~r.upd_tgl;
			end
			default: begin
			end
		endcase
	end

	// Inputs are sampled on the rising edge of the test clock
	always_ff @(posedge tck or negedge tap_arst_n) begin
		if (!tap_arst_n) begin
			r.state <= bst_pkg::BST_RESET;
			r.ir <= `BST_IR_RESET;
			r.ir_sh <= '0;
			r.dr_sh <= '0;
			r.byp <= 1'h0;
			r.upd_tgl <= 1'h0;
		end else begin
			r <= next_r;
		end
	end

	always_comb begin
		next_n.tdo_oe = (r.state == bst_pkg::BST_SHIFT_DR) ||
			(r.state == bst_pkg::BST_SHIFT_IR);
		if (r.state == bst_pkg::BST_SHIFT_IR) begin
			next_n.tdo = r.ir_sh[0];
		end else if (r.state == bst_pkg::BST_SHIFT_DR) begin
			next_n.tdo = sel_idcode ? r.dr_sh[0] : r.byp;
		end else begin
			next_n.tdo = `BST_TDO_IDLE;
		end
	end

	// Output stage moves only on the falling edge
	always_ff @(negedge tck or negedge tap_arst_n) begin
		if (!tap_arst_n) begin
			n.tdo <= `BST_TDO_IDLE;
			n.tdo_oe <= 1'h0;
		end else begin
			n <= next_n;
		end
	end

	assign tdo = n.tdo;
	assign tdo_oe = n.tdo_oe;

	// Test clock may stand still, so only levels and toggles cross
	bst_sync2 u_sync (
		.clock(clock),
		.rst_n(s.rst_sh[1]),
		// Carried inverted so the synchroniser's cleared flops read as in reset
		.d({r.upd_tgl, r.state != bst_pkg::BST_RESET}),
		.q(synced)
	);

	always_comb begin
		next_s = s;
		next_s.rst_sh = {s.rst_sh[0], 1'h1};
		next_s.in_reset = ~synced[0];
		next_s.tgl_seen = synced[1];
		next_s.ir_upd = synced[1] ^ s.tgl_seen;
		// Instruction held stable in the test domain when the toggle lands
		if (synced[1] ^ s.tgl_seen) begin
			next_s.ir = r.ir;
		end
	end

	// Reset release is delayed two cycles; assertion stays asynchronous
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s.rst_sh <= 2'h0;
			s.tgl_seen <= 1'h0;
			s.ir_upd <= 1'h0;
			s.ir <= `BST_IR_RESET;
			s.in_reset <= 1'h1;
		end else begin
			s <= next_s;
		end
	end

	assign sys_tap_reset = s.in_reset;
	assign sys_ir_upd = s.ir_upd;
	assign sys_ir = s.ir;

endmodule : bst_port

// [rtl/bst_sync2.sv]
// Two-flop level synchroniser into the system clock domain.
// Assumes inputs are levels or toggles that hold for several destination cycles.
`timescale 1ns/1ps

module bst_sync2 (
	// Destination clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Levels in and out
	input wire logic [1:0] d,
	output logic [1:0] q
);

	logic [1:0] meta;

	// First stage feeds only the second stage
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta <= 2'h0;
			q <= 2'h0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end

endmodule : bst_sync2

// [tb/bst_port_monitor.sv]
// Port checker for the test port.
// Assumes it is bound to bst_port.
`timescale 1ns/1ps

module bst_port_monitor (
	// Clocks and resets
	input wire logic clock,
	input wire logic rst_n,
	input wire logic tck,
	input wire logic trst_n,
	// Link
	input wire logic tms,
	input wire logic tms_conn,
	input wire logic tdi,
	input wire logic tdi_conn,
	input wire logic tdo,
	input wire logic tdo_oe,
	// Status
	input wire logic sys_tap_reset,
	input wire logic sys_ir_upd,
	input wire logic [3:0] sys_ir
);
	// Open pin reads high
	wire logic tmse = tms | !tms_conn;
	wire logic off = !trst_n || !rst_n;

	property p_neg;
		@(edge tck) disable iff (off) tck |-> $stable({tdo, tdo_oe});
	endproperty
	a_neg: assert property (p_neg) else $error("tdo moved on rising tck");
	property p_rise;
		@(posedge tck) disable iff (off) $rose(tdo_oe) |-> !$past(tmse) && !$past(tmse, 2);
	endproperty
	a_rise: assert property (p_rise) else $error("shift entered wrongly");
	property p_exit;
		@(posedge tck) disable iff (off) tmse |=> !tdo_oe;
	endproperty
	a_exit: assert property (p_exit) else $error("shift kept with mode high");
	property p_quiet;
		@(posedge tck) disable iff (off) !tdo_oe |-> !tdo;
	endproperty
	a_quiet: assert property (p_quiet) else $error("tdo active while off");
	property p_trst;
		@(posedge clock) disable iff (!rst_n) !trst_n [*4] |-> sys_tap_reset;
	endproperty
	a_trst: assert property (p_trst) else $error("test reset not seen");
	property p_pwr;
		@(posedge clock) disable iff (!rst_n) $rose(rst_n) |-> sys_tap_reset [*2];
	endproperty
	a_pwr: assert property (p_pwr) else $error("no reset at power-up");
	property p_upd;
		@(posedge clock) disable iff (!rst_n) sys_ir_upd |=> !sys_ir_upd;
	endproperty
	a_upd: assert property (p_upd) else $error("update pulse too long");
	property p_ir;
		@(posedge clock) disable iff (!rst_n) $changed(sys_ir) |-> sys_ir_upd;
	endproperty
	a_ir: assert property (p_ir) else $error("instruction moved alone");
endmodule : bst_port_monitor

bind bst_port bst_port_monitor bst_port_monitor_inst (.clock, .rst_n, .tck, .trst_n, .tms,
	.tms_conn, .tdi, .tdi_conn, .tdo, .tdo_oe, .sys_tap_reset, .sys_ir_upd, .sys_ir);

// [tb/bst_tap_ctrl.sv]
// Tester model driving the test link, one tck per step.
// Assumes one caller process.
`timescale 1ns/1ps

module bst_tap_ctrl (
	// Link
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe
);
	// Raise for a slow tester
	int hp = 3;
	initial begin
		tck = 1'h0;
		tms = 1'h1;
		tdi = 1'h0;
	end
	// Undriven tdo reads as z so a silent port never matches
	task automatic step(input logic m, input logic dv, output logic q);
		tms = m;
		tdi = dv;
		#hp tck = 1'h1;
		q = tdo_oe ? tdo : 1'bz;
		#hp tck = 1'h0;
	endtask : step
endmodule : bst_tap_ctrl

// [tb/testbench.sv]
// Bench for the test port with a tester model on the link.
// Assumes rtl files compiled first.
`timescale 1ns/1ps
`include "bst_defines.svh"

module testbench;
	logic clock = 1'h0;
	logic rst_n = 1'h0;
	logic trst_n = 1'h1;
	logic tms_conn = 1'h1;
	logic tdi_conn = 1'h1;
	logic tck, tms, tdi, tdo, tdo_oe, sys_tap_reset, sys_ir_upd, o;
	logic [3:0] sys_ir;
	logic [31:0] d;
	int n_mismatch = 0;
	int num_checks = 0;
	int n_upd = 0;

	always #12.5 clock = ~clock;

	// Counts instruction update pulses seen on the system side
	always @(posedge clock) begin
		if (sys_ir_upd === 1'h1) begin
			n_upd <= n_upd + 1;
		end
	end

	bst_port bst_port_inst (.clock, .rst_n, .tck, .trst_n, .tms, .tms_conn, .tdi, .tdi_conn,
		.tdo, .tdo_oe, .sys_tap_reset, .sys_ir_upd, .sys_ir);
	bst_tap_ctrl tester (.tck, .tms, .tdi, .tdo, .tdo_oe);

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : wait_clk

	// From idle through one scan back to idle, LSB first
	task automatic scan(input logic ir, input int n, input logic [31:0] din);
		d = '0;
		tester.step(1'h1, 1'h0, o);
		if (ir) begin
			tester.step(1'h1, 1'h0, o);
		end
		tester.step(1'h0, 1'h0, o);
		tester.step(1'h0, 1'h0, o);
		for (int i = 0; i < n; i++) begin
			tester.step(i == n - 1, din[i], o);
			d[i] = o;
		end
		tester.step(1'h1, 1'h0, o);
		tester.step(1'h0, 1'h0, o);
	endtask : scan

	task automatic t_idcode;
		check(sys_tap_reset, 1'h1);
		tester.step(1'h0, 1'h0, o);
		scan(1'h0, 32, 32'h0);
		check(d, `BST_IDCODE_DEFAULT);
		wait_clk(4);
		check(sys_tap_reset, 1'h0);
	endtask : t_idcode

	task automatic t_bypass;
		scan(1'h1, 4, 32'hF);
		check(d, 32'h1);
		wait_clk(6);
		check(sys_ir, 4'hF);
		check(n_upd, 32'h1);
		tester.hp = 20;
		scan(1'h0, 8, 32'hA5);
		check(d, 32'h4A);
		tester.hp = 3;
		@(posedge clock);
		tdi_conn <= 1'h0;
		scan(1'h0, 8, 32'h0);
		check(d, 32'hFE);
		@(posedge clock);
		tdi_conn <= 1'h1;
	endtask : t_bypass

	task automatic t_resets;
		@(posedge clock);
		tms_conn <= 1'h0;
		repeat (5) tester.step(1'h0, 1'h0, o);
		wait_clk(4);
		check(sys_tap_reset, 1'h1);
		@(posedge clock);
		tms_conn <= 1'h1;
		tester.step(1'h0, 1'h0, o);
		scan(1'h1, 4, 32'hF);
		@(posedge clock);
		trst_n <= 1'h0;
		wait_clk(5);
		check(sys_tap_reset, 1'h1);
		// Test clock running while test reset is held low must not leave reset
		repeat (3) tester.step(1'h0, 1'h0, o);
		wait_clk(4);
		check(sys_tap_reset, 1'h1);
		@(posedge clock);
		trst_n <= 1'h1;
		tester.step(1'h0, 1'h0, o);
		scan(1'h0, 32, 32'h0);
		check(d, `BST_IDCODE_DEFAULT);
		check(n_upd, 32'h2);
	endtask : t_resets

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		repeat (6) @(posedge clock);
		rst_n <= 1'h1;
		wait_clk(4);
		t_idcode;
		t_bypass;
		t_resets;
		report_and_stop;
	end

	// Tests need a few microseconds
	initial begin
		#100000;
		n_mismatch++;
		report_and_stop;
	end
endmodule : testbench
